/* File: rtl/bsma_chan.sv */
`timescale 1ns/1ns
`include "bsma_defines.svh"

module bsma_chan (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  bsma_chan_if.chan chan_port
);
  import bsma_pkg::*;

  bsma_chan_state_t s_q;
  bsma_chan_state_t s_d;
  logic [`BSMA_PTR_W-1:0] skip_ext;

  // odd skip bit dropped, then widened with the sign
  assign skip_ext = {{(`BSMA_PTR_W-`BSMA_WORD_W){chan_port.skip[`BSMA_WORD_W-1]}},
                     chan_port.skip[`BSMA_WORD_W-1:1], 1'b0};

  always_comb begin
    s_d = s_q;
    if (chan_port.load) begin
      s_d.ptr = chan_port.load_value;
    end else if (chan_port.step) begin
      s_d.ptr = s_q.ptr + `BSMA_PTR_W'(2);
    end else if (chan_port.row_end) begin
      s_d.ptr = s_q.ptr + skip_ext;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_q.ptr <= `BSMA_RST_PTR;
    end else begin
      s_q <= s_d;
    end
  end

  assign chan_port.ptr = s_q.ptr;

endmodule : bsma_chan

/* File: rtl/bsma_chan_if.sv */
`timescale 1ns/1ns
`include "bsma_defines.svh"

interface bsma_chan_if;
  logic load;
  logic [`BSMA_PTR_W-1:0] load_value;
  logic step;
  logic row_end;
  logic [`BSMA_WORD_W-1:0] skip;
  logic [`BSMA_PTR_W-1:0] ptr;

  modport chan (input load, input load_value, input step, input row_end, input skip, output ptr);
  modport seq (output load, output load_value, output step, output row_end, output skip, input ptr);
endinterface : bsma_chan_if

/* File: rtl/bsma_defines.svh */
`ifndef BSMA_DEFINES_SVH
`define BSMA_DEFINES_SVH

`define BSMA_AW 8
`define BSMA_DW 32
`define BSMA_WORD_W 16
`define BSMA_PTR_W 24
`define BSMA_MADDR_W 23
`define BSMA_NCHAN 4
`define BSMA_NSRC 3
`define BSMA_DESTINATION_ENABLE_CHAN 2'h3

`define BSMA_OFF_CTRL 8'h00
`define BSMA_OFF_DIM 8'h04
`define BSMA_OFF_STATE 8'h08
`define BSMA_OFF_IRQ_STAT 8'h0C
`define BSMA_OFF_IRQ_MASK 8'h10
`define BSMA_OFF_PROGRESS 8'h14
`define BSMA_OFF_PTR 4'h2
`define BSMA_OFF_SKIP 4'h3
`define BSMA_OFF_PRELOAD 4'h4

`define BSMA_WIDTH_LSB 0
`define BSMA_WIDTH_W 6
`define BSMA_HEIGHT_LSB 6
`define BSMA_HEIGHT_W 10
`define BSMA_ENABLE_W 4
`define BSMA_DONE_BIT 0
`define BSMA_BUSY_BIT 0

`define BSMA_RST_ENABLE 4'h0
`define BSMA_RST_WORD 16'h0000
`define BSMA_RST_PTR 24'h00_0000
`define BSMA_RST_DATA 32'h0000_0000

`endif

/* File: rtl/bsma_pad_note.sv */
`timescale 1ns/1ns

/* File: rtl/bsma_pkg.sv */
`include "bsma_defines.svh"

package bsma_pkg;

  typedef enum logic [1:0] {
    BSMA_IDLE = 2'b00,
    BSMA_FETCH = 2'b01,
    BSMA_ADVANCE = 2'b10
  } bsma_phase_t;

  typedef struct packed {
    bsma_phase_t phase;
    logic [`BSMA_ENABLE_W-1:0] enable;
    logic [`BSMA_WIDTH_W-1:0] width;
    logic [`BSMA_HEIGHT_W-1:0] height;
    logic [`BSMA_WIDTH_W:0] col;
    logic [`BSMA_HEIGHT_W:0] row;
    logic [1:0] chan;
    logic [`BSMA_NSRC-1:0][`BSMA_WORD_W-1:0] preload;
    logic [`BSMA_NCHAN-1:0][`BSMA_WORD_W-1:0] skip;
    logic irq_stat;
    logic irq_mask;
    logic mem_req;
    logic mem_we;
    logic [`BSMA_MADDR_W-1:0] mem_addr;
    logic [`BSMA_WORD_W-1:0] mem_wdata;
    logic [`BSMA_DW-1:0] prdata;
  } bsma_state_t;

  typedef struct packed {
    logic [`BSMA_PTR_W-1:0] ptr;
  } bsma_chan_state_t;

endpackage : bsma_pkg

/* File: rtl/bsma_top.sv */
`timescale 1ns/1ns
`include "bsma_defines.svh"

module bsma_top (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`BSMA_AW-1:0] paddr_in,
  input wire logic [`BSMA_DW-1:0] pwdata_in,
  output logic pready_out,
  output logic [`BSMA_DW-1:0] prdata_out,
  output logic pslverr_out,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [`BSMA_MADDR_W-1:0] mem_addr_out,
  output logic [`BSMA_WORD_W-1:0] mem_wdata_out,
  input wire logic [`BSMA_WORD_W-1:0] mem_rdata_in,
  input wire logic mem_ack_in,
  output logic irq_out
);
  import bsma_pkg::*;

  bsma_pkg::bsma_state_t s_q;
  bsma_pkg::bsma_state_t s_d;

  bsma_chan_if ch_if[`BSMA_NCHAN]();

  logic [`BSMA_NCHAN-1:0][`BSMA_PTR_W-1:0] ptr_view;
  logic busy;

  // bus side
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic [3:0] addr_group;
  logic [1:0] addr_chan;
  logic hit_ctrl;
  logic hit_dim;
  logic hit_state;
  logic hit_irq_stat;
  logic hit_irq_mask;
  logic hit_progress;
  logic hit_ptr;
  logic hit_skip;
  logic hit_preload;
  logic mapped;

  // walk side
  logic [`BSMA_WIDTH_W:0] width_total;
  logic [`BSMA_HEIGHT_W:0] height_total;
  logic last_col;
  logic last_row;
  logic mem_done;
  logic blit_done;
  logic done_clear;

  logic [`BSMA_DW-1:0] read_value;

  assign busy = (s_q.phase != BSMA_IDLE);

  // apb decode
  assign setup_phase = psel_in && !penable_in;
  assign access_phase = psel_in && penable_in;
  assign wr_access = access_phase && pwrite_in && mapped;
  assign addr_group = paddr_in[7:4];
  assign addr_chan = paddr_in[3:2];
  // one decode shared by reads, writes and the error response
  always_comb begin
    hit_ctrl = 1'b0;
    hit_dim = 1'b0;
    hit_state = 1'b0;
    hit_irq_stat = 1'b0;
    hit_irq_mask = 1'b0;
    hit_progress = 1'b0;
    hit_ptr = 1'b0;
    hit_skip = 1'b0;
    hit_preload = 1'b0;
    case (paddr_in)
      `BSMA_OFF_CTRL: begin
        hit_ctrl = 1'b1;
      end
      `BSMA_OFF_DIM: begin
        hit_dim = 1'b1;
      end
      `BSMA_OFF_STATE: begin
        hit_state = 1'b1;
      end
      `BSMA_OFF_IRQ_STAT: begin
        hit_irq_stat = 1'b1;
      end
      `BSMA_OFF_IRQ_MASK: begin
        hit_irq_mask = 1'b1;
      end
      `BSMA_OFF_PROGRESS: begin
        hit_progress = 1'b1;
      end
      default: begin
        hit_ctrl = 1'b0;
      end
    endcase
    // per-channel banks: four aligned words each, except three in the preload bank
    if (paddr_in[1:0] == 2'h0) begin
      case (addr_group)
        `BSMA_OFF_PTR: begin
          hit_ptr = 1'b1;
        end
        `BSMA_OFF_SKIP: begin
          hit_skip = 1'b1;
        end
        `BSMA_OFF_PRELOAD: begin
          // the destination owns no preload word, so its slot is a hole
          hit_preload = (addr_chan != `BSMA_DESTINATION_ENABLE_CHAN);
        end
        default: begin
          hit_ptr = 1'b0;
        end
      endcase
    end
  end
  assign mapped = hit_ctrl || hit_dim || hit_state || hit_irq_stat || hit_irq_mask
                  || hit_progress || hit_ptr || hit_skip || hit_preload;

  // zero-wait slave: read data is latched during setup
  assign pready_out = 1'b1;
  assign pslverr_out = access_phase && !mapped;
  assign prdata_out = s_q.prdata;

  // a zero field encodes the full count in the extra top bit
  assign width_total = {(s_q.width == `BSMA_WIDTH_W'(0)), s_q.width};
  assign height_total = {(s_q.height == `BSMA_HEIGHT_W'(0)), s_q.height};
  assign last_col = (s_q.col == width_total - `BSMA_WIDTH_W'(1) - 7'h00);
  assign last_row = (s_q.row == height_total - 11'h001);
  assign mem_done = (s_q.phase == BSMA_FETCH) && s_q.mem_req && mem_ack_in;
  assign blit_done = (s_q.phase == BSMA_ADVANCE) && last_col && last_row;
  assign done_clear = wr_access && hit_irq_stat && pwdata_in[`BSMA_DONE_BIT];

  // per-channel pointer units, all driven by the shared size counters
  for (genvar i = 0; i < `BSMA_NCHAN; i++) begin : g_chan
    // pointer writes are dropped while a blit runs to keep the walk coherent
    assign ch_if[i].load = wr_access && hit_ptr && (addr_chan == 2'(i)) && !busy;
    assign ch_if[i].load_value = pwdata_in[`BSMA_PTR_W-1:0];
    assign ch_if[i].step = mem_done && (s_q.chan == 2'(i));
    assign ch_if[i].row_end = (s_q.phase == BSMA_ADVANCE) && last_col && s_q.enable[i];
    assign ch_if[i].skip = s_q.skip[i];
    assign ptr_view[i] = ch_if[i].ptr;

    bsma_chan u_chan (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .chan_port(ch_if[i])
    );
  end

  always_comb begin
    read_value = `BSMA_RST_DATA;
    if (hit_ctrl) begin
      read_value[`BSMA_ENABLE_W-1:0] = s_q.enable;
    end else if (hit_state) begin
      read_value[`BSMA_BUSY_BIT] = busy;
    end else if (hit_irq_stat) begin
      read_value[`BSMA_DONE_BIT] = s_q.irq_stat;
    end else if (hit_irq_mask) begin
      read_value[`BSMA_DONE_BIT] = s_q.irq_mask;
    end else if (hit_progress) begin
      read_value[`BSMA_WIDTH_W:0] = s_q.col;
      read_value[16+`BSMA_HEIGHT_W:16] = s_q.row;
    end else if (hit_ptr) begin
      read_value[`BSMA_PTR_W-1:0] = ptr_view[addr_chan];
    end else if (hit_preload) begin
      read_value[`BSMA_WORD_W-1:0] = s_q.preload[addr_chan];
    end
  end

  always_comb begin
    s_d = s_q;

    if (setup_phase) begin
      s_d.prdata = read_value;
    end

    // register writes
    if (wr_access) begin
      if (hit_ctrl && !busy) begin
        s_d.enable = pwdata_in[`BSMA_ENABLE_W-1:0];
      end

      if (hit_irq_mask) begin
        s_d.irq_mask = pwdata_in[`BSMA_DONE_BIT];
      end

      if (hit_skip && !busy) begin
        s_d.skip[addr_chan] = pwdata_in[`BSMA_WORD_W-1:0];
      end

      if (hit_preload && !busy) begin
        s_d.preload[addr_chan] = pwdata_in[`BSMA_WORD_W-1:0];
      end

      // a size write while busy is ignored rather than restarting mid-walk
      if (hit_dim && !busy) begin
        s_d.width = pwdata_in[`BSMA_WIDTH_LSB +: `BSMA_WIDTH_W];
        s_d.height = pwdata_in[`BSMA_HEIGHT_LSB +: `BSMA_HEIGHT_W];
        s_d.col = 7'h00;
        s_d.row = 11'h000;
        s_d.chan = 2'h0;
        s_d.phase = BSMA_FETCH;
      end
    end

    case (s_q.phase)
      BSMA_IDLE: begin
        s_d.mem_req = 1'b0;
        s_d.mem_we = 1'b0;
      end

      BSMA_FETCH: begin
        if (!s_q.enable[s_q.chan]) begin
          // skipped channel: no memory cycle, preload word stays in use
          if (s_q.chan == `BSMA_DESTINATION_ENABLE_CHAN) begin
            s_d.phase = BSMA_ADVANCE;
          end else begin
            s_d.chan = s_q.chan + 2'h1;
          end
        end else if (!s_q.mem_req) begin
          s_d.mem_req = 1'b1;
          s_d.mem_we = (s_q.chan == `BSMA_DESTINATION_ENABLE_CHAN);
          s_d.mem_addr = ptr_view[s_q.chan][`BSMA_PTR_W-1:1];
          // plain copy from the first source; no logic function here
          s_d.mem_wdata = s_q.preload[0];
        end else if (mem_ack_in) begin
          s_d.mem_req = 1'b0;
          s_d.mem_we = 1'b0;
          if (s_q.chan == `BSMA_DESTINATION_ENABLE_CHAN) begin
            s_d.phase = BSMA_ADVANCE;
          end else begin
            s_d.preload[s_q.chan] = mem_rdata_in;
            s_d.chan = s_q.chan + 2'h1;
          end
        end
      end

      BSMA_ADVANCE: begin
        s_d.chan = 2'h0;
        if (last_col) begin
          s_d.col = 7'h00;
          if (last_row) begin
            s_d.phase = BSMA_IDLE;
          end else begin
            s_d.row = s_q.row + 11'h001;
            s_d.phase = BSMA_FETCH;
          end
        end else begin
          s_d.col = s_q.col + 7'h01;
          s_d.phase = BSMA_FETCH;
        end
      end

      default: begin
        s_d.phase = BSMA_IDLE;
        s_d.mem_req = 1'b0;
        s_d.mem_we = 1'b0;
      end
    endcase

    // completion sets the flag even in the cycle software clears it
    if (blit_done) begin
      s_d.irq_stat = 1'b1;
    end else if (done_clear) begin
      s_d.irq_stat = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_q.phase <= BSMA_IDLE;
      s_q.enable <= `BSMA_RST_ENABLE;
      s_q.width <= 6'h00;
      s_q.height <= 10'h000;
      s_q.col <= 7'h00;
      s_q.row <= 11'h000;
      s_q.chan <= 2'h0;
      s_q.preload <= '0;
      s_q.skip <= '0;
      s_q.irq_stat <= 1'b0;
      s_q.irq_mask <= 1'b0;
      s_q.mem_req <= 1'b0;
      s_q.mem_we <= 1'b0;
      s_q.mem_addr <= 23'h00_0000;
      s_q.mem_wdata <= `BSMA_RST_WORD;
      s_q.prdata <= `BSMA_RST_DATA;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_req_out = s_q.mem_req;
  assign mem_we_out = s_q.mem_we;
  assign mem_addr_out = s_q.mem_addr;
  assign mem_wdata_out = s_q.mem_wdata;
  assign irq_out = s_q.irq_stat && s_q.irq_mask;

endmodule : bsma_top

/* File: sim/bsma_checker.sv */
`timescale 1ns/1ns
`include "bsma_defines.svh"
module bsma_checker (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`BSMA_AW-1:0] paddr_in,
  input wire logic [`BSMA_DW-1:0] pwdata_in,
  input wire logic pready_out,
  input wire logic [`BSMA_DW-1:0] prdata_out,
  input wire logic pslverr_out,
  input wire logic mem_req_out,
  input wire logic mem_we_out,
  input wire logic [`BSMA_MADDR_W-1:0] mem_addr_out,
  input wire logic [`BSMA_WORD_W-1:0] mem_wdata_out,
  input wire logic [`BSMA_WORD_W-1:0] mem_rdata_in,
  input wire logic mem_ack_in,
  input wire logic irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_err_in_access: assert property (pslverr_out |-> psel_in && penable_in) else $error("error outside access");
  a_req_holds: assert property (mem_req_out && !mem_ack_in |=> mem_req_out &&
    $stable({mem_we_out, mem_addr_out, mem_wdata_out})) else $error("request changed before ack");
  a_req_drops: assert property (mem_req_out && mem_ack_in |=> !mem_req_out) else $error("req not dropped");
  a_err_unmapped: assert property (psel_in && penable_in && paddr_in == 8'h4C |-> pslverr_out)
    else $error("no error on hole");
  a_err_mapped: assert property (psel_in && penable_in && paddr_in == 8'h00 |-> !pslverr_out)
    else $error("error on control");
  a_size_reads_zero: assert property (psel_in && !penable_in && !pwrite_in && paddr_in == 8'h04
    |=> prdata_out == 32'h0000_0000) else $error("size readable");
  a_mask_off_quiet: assert property (psel_in && penable_in && pwrite_in && paddr_in == 8'h10 &&
    !pwdata_in[0] |=> !irq_out) else $error("irq while masked");
  a_done_when_idle: assert property ($rose(irq_out) |-> !mem_req_out && !$past(mem_req_out))
    else $error("done during memory cycle");
  c_destination_enable_write: cover property (mem_req_out && mem_ack_in && mem_we_out);
  c_irq: cover property ($rose(irq_out));
  c_err: cover property (pslverr_out);
endmodule : bsma_checker

bind bsma_top bsma_checker u_chk (.sys_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .mem_req_out, .mem_we_out,
  .mem_addr_out, .mem_wdata_out, .mem_rdata_in, .mem_ack_in, .irq_out);

/* File: sim/bsma_mem_model.sv */
`timescale 1ns/1ns
`include "bsma_defines.svh"
module bsma_mem_model (
  input wire logic sys_clk_in,
  input wire logic slow_in,
  input wire logic mem_req_in,
  input wire logic [`BSMA_MADDR_W-1:0] mem_addr_in,
  output logic [`BSMA_WORD_W-1:0] mem_rdata_out,
  output logic mem_ack_out
);
  logic [1:0] wait_q;
  initial begin
    wait_q = 2'h0;
    mem_ack_out = 1'b0;
    mem_rdata_out = 16'h0000;
  end
  always @(posedge sys_clk_in) begin
    mem_ack_out <= 1'b0;
    // data toggles outside ack so a stale sample never matches
    mem_rdata_out <= ~mem_rdata_out;
    if (mem_req_in && !mem_ack_out) begin
      if (!slow_in || wait_q == 2'h2) begin
        mem_ack_out <= 1'b1;
        mem_rdata_out <= mem_addr_in[15:0] ^ 16'ha5a5;
        wait_q <= 2'h0;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule : bsma_mem_model

/* File: sim/tb.sv */
`timescale 1ns/1ns
`include "bsma_defines.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import bsma_pkg::*;
  logic sys_clk_in, sys_rst_in, psel, pen, pwr, slow, pready, pslverr, req, we, ack, irq, e;
  logic [`BSMA_AW-1:0] paddr;
  logic [`BSMA_DW-1:0] pwdata, prdata, r;
  logic [`BSMA_MADDR_W-1:0] maddr;
  logic [`BSMA_WORD_W-1:0] wdata, rdata;
  logic [38:0] exp_q[$];
  logic [38:0] got;
  int miscompares = 0, tests_run = 0, rds = 0;
  bsma_top dut (.sys_clk_in, .sys_rst_in, .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .mem_req_out(req), .mem_we_out(we), .mem_addr_out(maddr),
    .mem_wdata_out(wdata), .mem_rdata_in(rdata), .mem_ack_in(ack), .irq_out(irq));
  bsma_mem_model mem (.sys_clk_in, .slow_in(slow), .mem_req_in(req), .mem_addr_in(maddr),
    .mem_rdata_out(rdata), .mem_ack_out(ack));
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  task automatic summarize;
    $display("checks %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk_in);
    pen <= 1'b1;
    do @(posedge sys_clk_in); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    // one idle edge so a following call never reassigns psel in this time step
    @(posedge sys_clk_in);
  endtask : apb
  always @(posedge sys_clk_in) if (req && ack) begin
    if (!we) rds++;
    else if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
    else begin
      got = exp_q.pop_front();
      `CHK({maddr, wdata}, got)
    end
  end
  task automatic blit(input logic [3:0] en, input logic [5:0] wf, input logic [9:0] hf,
      input logic [23:0] p0, input logic [23:0] p3, input logic [15:0] s0, input logic [15:0] s3);
    int w, h;
    logic [23:0] a0, a3;
    logic [15:0] pre;
    w = (wf == 6'h00) ? 64 : int'(wf);
    h = (hf == 10'h000) ? 1024 : int'(hf);
    pre = 16'($urandom);
    apb(1'b1, 8'h00, {28'h000_0000, en});
    apb(1'b1, 8'h20, 32'(p0));
    apb(1'b1, 8'h2C, 32'(p3));
    apb(1'b1, 8'h30, 32'(s0));
    apb(1'b1, 8'h3C, 32'(s3));
    apb(1'b1, 8'h40, 32'(pre));
    a0 = p0;
    a3 = p3;
    for (int y = 0; y < h; y++) begin
      for (int x = 0; x < w; x++) begin
        exp_q.push_back({a3[23:1], en[0] ? (a0[16:1] ^ 16'ha5a5) : pre});
        a0 += 24'h00_0002;
        a3 += 24'h00_0002;
      end
      a0 += {{8{s0[15]}}, s0[15:1], 1'b0};
      a3 += {{8{s3[15]}}, s3[15:1], 1'b0};
    end
    rds = 0;
    apb(1'b1, 8'h04, {16'h0000, hf, wf});
    for (int i = 0; i < 40000 && irq !== 1'b1; i++) @(posedge sys_clk_in);
    `CHK(irq, 1'b1)
    `CHK(exp_q.size(), 0)
    `CHK(rds, w * h * (en[0] + en[1] + en[2]))
    apb(1'b0, 8'h0C, 32'h0000_0000);
    `CHK(r, 32'h0000_0001)
    apb(1'b1, 8'h0C, 32'h0000_0001);
    @(posedge sys_clk_in);
    `CHK(irq, 1'b0)
    $display("test done t=%0t en=%h w=%0d h=%0d", $time, en, w, h);
  endtask : blit
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
  initial begin
    sys_rst_in = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; slow = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000;
    void'($urandom(32'hf8334d88));
    repeat (2) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge sys_clk_in);
    apb(1'b0, 8'h00, 32'h0000_0000);
    `CHK(r, 32'h0000_0000)
    apb(1'b0, 8'h4C, 32'h0000_0000);
    `CHK({e, r}, 33'h1_0000_0000)
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CHK(r, 32'h0000_0000)
    apb(1'b1, 8'h10, 32'h0000_0001);
    // odd skip: effective 4, so 2*3+4 spans a 10 byte plane
    blit(4'h9, 6'h03, 10'h002, 24'h00_0100, 24'h00_0400, 16'h0005, 16'hfff8);
    slow <= 1'b1;
    blit(4'h9, 6'h01, 10'h001, 24'($urandom) & 24'h0f_fffe, 24'h00_2000, 16'($urandom), 16'h0002);
    // full 64-word width is fine here: nothing is shifted or masked
    blit(4'h8, 6'h00, 10'h001, 24'h00_0000, 24'($urandom) & 24'h0f_fffe, 16'h0000, 16'h0010);
    slow <= 1'b0;
    blit(4'hf, 6'h02, 10'h003, 24'h00_1000, 24'h00_3000, 16'hfffc, 16'h0006);
    blit(4'h8, 6'h01, 10'h000, 24'h00_0000, 24'h00_8000, 16'h0000, 16'hfffe);
    apb(1'b1, 8'h10, 32'h0000_0000);
    summarize();
  end
endmodule : tb
